// file: hdl/lfg_pkg.sv
package lfg_pkg;
	// Clock and timing
	localparam int CLK_HZ = 10_000_000;
	localparam int CLK_PER_US = CLK_HZ / 1_000_000;
	localparam int DEBOUNCE_MS = 37;
	localparam int DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
	localparam int PERSIST_MS = 5;
	localparam int PERSIST_CYC = PERSIST_MS * (CLK_HZ / 1000);
	// Ramp time is 2.5 us per ohm, kept in tenths of a microsecond
	localparam int RAMP_TENTH_US_PER_OHM = 25;
	localparam int CYC_PER_OHM = RAMP_TENTH_US_PER_OHM * CLK_PER_US / 10;
	localparam int GROUNDED_RAMP_US = 70;
	localparam int GROUNDED_RAMP_CYC = GROUNDED_RAMP_US * CLK_PER_US;

	// Gamma table shape
	localparam int GAMMA_LEVELS = 63;
	localparam logic [5:0] GAMMA_TOP = 6'h3e;
	localparam logic [9:0] GAMMA_FULL = 10'h3e8;

	// Derating, in percent of set current
	localparam logic [6:0] FULL_PCT = 7'h64;
	localparam logic [6:0] SHORT_PCT = 7'h14;
	localparam int ROLLBACK_PCT_PER_DEG = 3;

	// Register offsets (byte addresses)
	localparam logic [7:0] ADR_FADE_IN = 8'h00;
	localparam logic [7:0] ADR_FADE_OUT = 8'h04;
	localparam logic [7:0] ADR_LEVEL = 8'h08;
	localparam logic [7:0] ADR_CTRL = 8'h0c;
	localparam logic [7:0] ADR_STATUS = 8'h10;

	// Reset values
	localparam logic [19:0] FADE_IN_RST = 20'h1_86a0;
	localparam logic [19:0] FADE_OUT_RST = 20'h1_86a0;
	localparam logic [7:0] LEVEL_RST = 8'h14;
	localparam logic [0:0] CTRL_RST = 1'h0;

	// Field positions
	localparam int CTRL_PWM_INV_BIT = 0;
	localparam int ST_LATCH_BIT = 0;
	localparam int ST_UVLO_BIT = 1;
	localparam int ST_SHORT_BIT = 2;
	localparam int ST_TBLOCK_BIT = 3;
	localparam int ST_BTN_BIT = 4;
	localparam int ST_STATE_LSB = 8;
	localparam int ST_IDX_LSB = 16;

	typedef enum logic [3:0] {
		RAMP_OFF = 4'b0001,
		RAMP_RISE = 4'b0010,
		RAMP_ON = 4'b0100,
		RAMP_FALL = 4'b1000
	} lfg_ramp_e;
endpackage

// file: hdl/lfg_gamma_rom.sv
`timescale 1ns/1ps
`default_nettype none
module lfg_gamma_rom (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [5:0] addr,
	output logic [9:0] q
);
	import lfg_pkg::*;

	// Fixed, rising table on a 0..1000 scale
	logic [9:0] table_val;
	always_comb begin
		unique case (addr)
			6'd0: table_val = 10'd0;
			6'd1: table_val = 10'd2;
			6'd2: table_val = 10'd4;
			6'd3: table_val = 10'd6;
			6'd4: table_val = 10'd8;
			6'd5: table_val = 10'd10;
			6'd6: table_val = 10'd12;
			6'd7: table_val = 10'd16;
			6'd8: table_val = 10'd20;
			6'd9: table_val = 10'd24;
			6'd10: table_val = 10'd28;
			6'd11: table_val = 10'd32;
			6'd12: table_val = 10'd36;
			6'd13: table_val = 10'd42;
			6'd14: table_val = 10'd48;
			6'd15: table_val = 10'd54;
			6'd16: table_val = 10'd60;
			6'd17: table_val = 10'd66;
			6'd18: table_val = 10'd72;
			6'd19: table_val = 10'd80;
			6'd20: table_val = 10'd88;
			6'd21: table_val = 10'd96;
			6'd22: table_val = 10'd104;
			6'd23: table_val = 10'd112;
			6'd24: table_val = 10'd120;
			6'd25: table_val = 10'd130;
			6'd26: table_val = 10'd140;
			6'd27: table_val = 10'd150;
			6'd28: table_val = 10'd160;
			6'd29: table_val = 10'd170;
			6'd30: table_val = 10'd180;
			6'd31: table_val = 10'd194;
			6'd32: table_val = 10'd208;
			6'd33: table_val = 10'd222;
			6'd34: table_val = 10'd236;
			6'd35: table_val = 10'd250;
			6'd36: table_val = 10'd264;
			6'd37: table_val = 10'd282;
			6'd38: table_val = 10'd300;
			6'd39: table_val = 10'd318;
			6'd40: table_val = 10'd336;
			6'd41: table_val = 10'd354;
			6'd42: table_val = 10'd372;
			6'd43: table_val = 10'd394;
			6'd44: table_val = 10'd416;
			6'd45: table_val = 10'd438;
			6'd46: table_val = 10'd460;
			6'd47: table_val = 10'd482;
			6'd48: table_val = 10'd504;
			6'd49: table_val = 10'd534;
			6'd50: table_val = 10'd564;
			6'd51: table_val = 10'd594;
			6'd52: table_val = 10'd624;
			6'd53: table_val = 10'd654;
			6'd54: table_val = 10'd684;
			6'd55: table_val = 10'd722;
			6'd56: table_val = 10'd760;
			6'd57: table_val = 10'd798;
			6'd58: table_val = 10'd836;
			6'd59: table_val = 10'd874;
			6'd60: table_val = 10'd914;
			6'd61: table_val = 10'd956;
			6'd62: table_val = GAMMA_FULL;
			// Index 63 never used; clamp to full scale
			default: table_val = GAMMA_FULL;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			q <= 10'h000;
		else
			q <= table_val;
	end
endmodule
`default_nettype wire

// file: hdl/lfg_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module lfg_ctrl #(
	parameter int DEBOUNCE_CYCLES = lfg_pkg::DEBOUNCE_CYC,
	parameter int PERSIST_CYCLES = lfg_pkg::PERSIST_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic btn_n_pin,
	input wire logic pwm_pin,
	input wire logic vcc_below_lockout,
	input wire logic vcc_below_retain,
	input wire logic vcc_above_recover,
	input wire logic out_short_det,
	input wire logic temp_over_rollback,
	input wire logic temp_over_off,
	input wire logic [7:0] temp_excess_deg,
	output logic src_en,
	output logic [9:0] src_level,
	output logic [6:0] src_derate_pct,
	output logic [7:0] current_level_set
);
	import lfg_pkg::*;

	localparam int NSYNC = 16;

	function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (sel[b])
				r[8*b +: 8] = new_v[8*b +: 8];
		end
		return r;
	endfunction

	// Pin synchronisers; stage one feeds only stage two
	logic [NSYNC-1:0] pin_raw;
	logic [NSYNC-1:0] sync_a;
	logic [NSYNC-1:0] sync_b;
	assign pin_raw = {temp_excess_deg, temp_over_off, temp_over_rollback,
		out_short_det, vcc_above_recover,
		vcc_below_retain, vcc_below_lockout,
		pwm_pin, btn_n_pin};
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					sync_a[gi] <= (gi == 0);
					sync_b[gi] <= (gi == 0);
				end else begin
					sync_a[gi] <= pin_raw[gi];
					sync_b[gi] <= sync_a[gi];
				end
			end
		end
	endgenerate

	wire btn_s = sync_b[0];
	wire pwm_s = sync_b[1];
	wire below_lock_s = sync_b[2];
	wire below_ret_s = sync_b[3];
	wire above_rec_s = sync_b[4];
	wire short_s = sync_b[5];
	wire over_roll_s = sync_b[6];
	wire over_off_s = sync_b[7];
	wire [7:0] excess_s = sync_b[15:8];

	// Registers
	logic [19:0] fade_in_time_set;
	logic [19:0] fade_out_time_set;
	logic [0:0] ctrl;
	// Toggle latch survives lockout; only retention loss, shutdown or a debounced button press clears it
	logic latch_on;
	logic uvlo;
	logic short_fault;
	logic therm_block;
	logic btn_db;
	logic [18:0] db_cnt;
	logic [16:0] sf_cnt;
	logic [5:0] idx;
	logic [25:0] acc;
	lfg_ramp_e state;
	lfg_ramp_e next_state;
	logic [9:0] rom_q;

	// Wishbone slave: one wait state, ack lasts one cycle
	// Ack masks the request so a held strobe cannot write twice in a row
	wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire wb_wr = wb_req && wb_we_i;

	wire [31:0] status_word = (32'(latch_on) << ST_LATCH_BIT)
		| (32'(uvlo) << ST_UVLO_BIT)
		| (32'(short_fault) << ST_SHORT_BIT)
		| (32'(therm_block) << ST_TBLOCK_BIT)
		| (32'(btn_db) << ST_BTN_BIT)
		| (32'(state) << ST_STATE_LSB)
		| (32'(idx) << ST_IDX_LSB);
	wire [31:0] rd_data = (wb_adr_i == ADR_FADE_IN) ? {12'h000, fade_in_time_set} :
		(wb_adr_i == ADR_FADE_OUT) ? {12'h000, fade_out_time_set} :
		(wb_adr_i == ADR_LEVEL) ? {24'h00_0000, current_level_set} :
		(wb_adr_i == ADR_CTRL) ? {31'h0000_0000, ctrl} :
		(wb_adr_i == ADR_STATUS) ? status_word : 32'h0000_0000;
	wire [31:0] wr_fin = lane_merge({12'h000, fade_in_time_set}, wb_dat_i, wb_sel_i);
	wire [31:0] wr_fout = lane_merge({12'h000, fade_out_time_set}, wb_dat_i, wb_sel_i);
	wire [31:0] wr_lvl = lane_merge({24'h00_0000, current_level_set}, wb_dat_i, wb_sel_i);
	wire [31:0] wr_ctl = lane_merge({31'h0000_0000, ctrl}, wb_dat_i, wb_sel_i);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= wb_req ? rd_data : 32'h0000_0000;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			fade_in_time_set <= FADE_IN_RST;
			fade_out_time_set <= FADE_OUT_RST;
			current_level_set <= LEVEL_RST;
			ctrl <= CTRL_RST;
		end else if (wb_wr) begin
			if (wb_adr_i == ADR_FADE_IN)
				fade_in_time_set <= wr_fin[19:0];
			if (wb_adr_i == ADR_FADE_OUT)
				fade_out_time_set <= wr_fout[19:0];
			if (wb_adr_i == ADR_LEVEL)
				current_level_set <= wr_lvl[7:0];
			if (wb_adr_i == ADR_CTRL)
				ctrl <= wr_ctl[0:0];
		end
	end

	// Button debounce, both edges; never gated by fade settings
	// Release also needs the full time, so bounce on release cannot retoggle
	wire btn_diff = (btn_s != btn_db);
	wire db_done = btn_diff && (db_cnt == 19'(DEBOUNCE_CYCLES - 1));
	wire toggle_req = db_done && btn_db;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			db_cnt <= 19'h0_0000;
			btn_db <= 1'b1;
		end else begin
			db_cnt <= (btn_diff && !db_done) ? db_cnt + 19'h0_0001 : 19'h0_0000;
			if (db_done)
				btn_db <= btn_s;
		end
	end

	// Short fault qualification
	wire sf_done = short_s && (sf_cnt == 17'(PERSIST_CYCLES - 1));
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sf_cnt <= 17'h0_0000;
			short_fault <= 1'b0;
		end else begin
			sf_cnt <= (short_s && !sf_done && !short_fault) ? sf_cnt + 17'h0_0001 : 17'h0_0000;
			if (!short_s)
				short_fault <= 1'b0;
			else if (sf_done)
				short_fault <= 1'b1;
		end
	end

	// Supply and thermal state; set terms win over clears for uvlo and therm_block, but latch clears win over the toggle
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			uvlo <= 1'b0;
			therm_block <= 1'b0;
			latch_on <= 1'b0;
		end else begin
			if (below_lock_s || below_ret_s)
				uvlo <= 1'b1;
			else if (above_rec_s)
				uvlo <= 1'b0;
			if (over_off_s)
				therm_block <= 1'b1;
			else if (!over_roll_s)
				therm_block <= 1'b0;
			if (below_ret_s || over_off_s)
				latch_on <= 1'b0;
			else if (toggle_req && (latch_on || !therm_block))
				latch_on <= !latch_on;
		end
	end

	// Step timing: per clock add the step count, step when the duration is reached
	wire rising = (state == RAMP_RISE);
	wire ramping = rising || (state == RAMP_FALL);
	wire [19:0] dir_set = rising ? fade_in_time_set : fade_out_time_set;
	// A zero setting would step every cycle; fall back to the short fixed ramp
	wire [25:0] period = (dir_set == 20'h0_0000) ? 26'(GROUNDED_RAMP_CYC) :
		26'(dir_set) * 26'(CYC_PER_OHM);
	// Remainder is carried, so long ramps do not drift
	wire [25:0] acc_sum = acc + 26'(GAMMA_TOP);
	wire tick = ramping && (acc_sum >= period);
	wire dir_change = (next_state != state);

	always_comb begin
		next_state = state;
		unique case (state)
			RAMP_OFF: if (latch_on) next_state = RAMP_RISE;
			RAMP_RISE: begin
				if (!latch_on)
					next_state = RAMP_FALL;
				else if (idx == GAMMA_TOP)
					next_state = RAMP_ON;
			end
			RAMP_ON: if (!latch_on) next_state = RAMP_FALL;
			RAMP_FALL: begin
				if (latch_on)
					next_state = RAMP_RISE;
				else if (idx == 6'h00)
					next_state = RAMP_OFF;
			end
			default: next_state = RAMP_OFF;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= RAMP_OFF;
			idx <= 6'h00;
			acc <= 26'h000_0000;
		end else if (below_ret_s) begin
			state <= RAMP_OFF;
			idx <= 6'h00;
			acc <= 26'h000_0000;
		end else begin
			state <= next_state;
			acc <= (!ramping || dir_change) ? 26'h000_0000 : tick ? acc_sum - period : acc_sum;
			if (tick && rising && idx != GAMMA_TOP)
				idx <= idx + 6'h01;
			else if (tick && !rising && idx != 6'h00)
				idx <= idx - 6'h01;
		end
	end

	lfg_gamma_rom u_rom (
		.clk(clk),
		.sys_rst(sys_rst),
		.addr(idx),
		.q(rom_q)
	);

	// Outputs
	wire pwm_act = pwm_s ^ ctrl[CTRL_PWM_INV_BIT];
	wire button_path = latch_on || (state != RAMP_OFF);
	wire [9:0] next_level = button_path ? rom_q :
		(pwm_act ? GAMMA_FULL : 10'h000);
	wire [9:0] roll_cut = 10'(excess_s) * 10'(ROLLBACK_PCT_PER_DEG);
	// Derate floors at zero; hotter than that is left to shutdown
	wire [6:0] roll_pct = !over_roll_s ? FULL_PCT :
		(roll_cut >= 10'(FULL_PCT)) ? 7'h00 : FULL_PCT - roll_cut[6:0];
	wire [6:0] next_pct = (short_fault && roll_pct > SHORT_PCT) ? SHORT_PCT : roll_pct;
	// No fade on shutdown or lockout; the source drops at once
	wire next_en = !uvlo && !therm_block && !below_lock_s && !below_ret_s;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			src_en <= 1'b0;
			src_level <= 10'h000;
			src_derate_pct <= 7'h00;
		end else begin
			src_en <= next_en;
			src_level <= next_en ? next_level : 10'h000;
			src_derate_pct <= next_pct;
		end
	end
endmodule
`default_nettype wire

// file: dv/lfg_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
module lfg_ctrl_props #(
	parameter int PERSIST_CYCLES = 10
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic vcc_below_lockout,
	input wire logic out_short_det,
	input wire logic temp_over_off,
	input wire logic src_en,
	input wire logic [9:0] src_level,
	input wire logic [6:0] src_derate_pct,
	input wire logic [7:0] current_level_set
);
	import lfg_pkg::*;
	logic [15:0] short_cnt;
	// Raw count; sync and output flops add a few cycles of slack
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			short_cnt <= 16'h0000;
		end else begin
			short_cnt <= out_short_det ? short_cnt + 16'h0001 : 16'h0000;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	property p_ack_next;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	property p_dat_idle;
		!wb_ack_o |-> wb_dat_o == 32'h0000_0000;
	endproperty
	a_dat_idle: assert property (p_dat_idle) else $error("read data without ack");
	property p_lvl_wr;
		wb_ack_o && wb_we_i && wb_adr_i == ADR_LEVEL && wb_sel_i[0] |-> ##2 current_level_set == $past(wb_dat_i[7:0], 2);
	endproperty
	a_lvl_wr: assert property (p_lvl_wr) else $error("level write not seen");
	property p_off_zero;
		!src_en |-> src_level == 10'h000;
	endproperty
	a_off_zero: assert property (p_off_zero) else $error("level while source off");
	property p_lvl_max;
		src_level <= GAMMA_FULL;
	endproperty
	a_lvl_max: assert property (p_lvl_max) else $error("level above full scale");
	property p_pct_max;
		src_derate_pct <= FULL_PCT;
	endproperty
	a_pct_max: assert property (p_pct_max) else $error("derate above full");
	property p_uvlo_off;
		vcc_below_lockout [*6] |-> !src_en;
	endproperty
	a_uvlo_off: assert property (p_uvlo_off) else $error("source on in lockout");
	property p_shdn_off;
		temp_over_off [*6] |-> !src_en;
	endproperty
	a_shdn_off: assert property (p_shdn_off) else $error("source on in shutdown");
	property p_short_cap;
		short_cnt > 16'(PERSIST_CYCLES + 6) |-> src_derate_pct <= SHORT_PCT;
	endproperty
	a_short_cap: assert property (p_short_cap) else $error("short not derated");
	c_full: cover property (src_level == GAMMA_FULL);
	c_short: cover property (short_cnt > 16'(PERSIST_CYCLES + 6));
	c_shdn: cover property (temp_over_off && !src_en);
endmodule
bind lfg_ctrl lfg_ctrl_props #(.PERSIST_CYCLES(PERSIST_CYCLES)) i_lfg_ctrl_props (.clk, .sys_rst, .wb_cyc_i,
	.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .vcc_below_lockout,
	.out_short_det, .temp_over_off, .src_en, .src_level, .src_derate_pct, .current_level_set);
`default_nettype wire

// file: dv/lfg_btn_src.sv
`timescale 1ns/1ps
`default_nettype none
module lfg_btn_src (
	input wire logic clk,
	input wire logic go,
	input wire logic [15:0] hold,
	output logic btn_n_pin,
	output logic busy
);
	logic [16:0] cnt = 17'h0_0000;
	// Pull-up keeps the idle level high
	initial btn_n_pin = 1'b1;
	initial busy = 1'b0;
	always @(posedge clk) begin
		if (go && !busy) begin
			busy <= 1'b1;
			cnt <= {hold, 1'b0};
			btn_n_pin <= 1'b0;
		end else if (busy) begin
			cnt <= cnt - 17'h0_0001;
			if (cnt == {1'b0, hold}) btn_n_pin <= 1'b1;
			if (cnt == 17'h0_0001) busy <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// file: dv/lfg_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module lfg_ctrl_tb_top;
	import lfg_pkg::*;
	logic clk = 1'b0, sys_rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, pwm = 1'b0, go = 1'b0;
	logic lock = 1'b0, ret = 1'b0, rec = 1'b1, sh = 1'b0, trb = 1'b0, toff = 1'b0;
	logic [7:0] adr = 8'h00, exc = 8'h00;
	logic [31:0] dat = 32'h0000_0000, r;
	logic [15:0] hold = 16'h0028;
	logic [3:0] sel = 4'hf, lanes = 4'hf;
	logic [9:0] mn;
	wire logic btn_n, busy, ack, en;
	wire logic [31:0] rdat;
	wire logic [9:0] lvl;
	wire logic [6:0] pct;
	wire logic [7:0] lset;
	logic [31:0] exp_q[$];
	int bad_count = 0, compares = 0, n, e;
	initial forever #50 clk = ~clk;
	lfg_ctrl #(.DEBOUNCE_CYCLES(20), .PERSIST_CYCLES(10)) i_lfg_ctrl (.clk, .sys_rst, .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .btn_n_pin(btn_n), .pwm_pin(pwm), .vcc_below_lockout(lock), .vcc_below_retain(ret),
		.vcc_above_recover(rec), .out_short_det(sh), .temp_over_rollback(trb), .temp_over_off(toff),
		.temp_excess_deg(exc), .src_en(en), .src_level(lvl), .src_derate_pct(pct), .current_level_set(lset));
	lfg_btn_src i_lfg_btn_src (.clk, .go, .hold, .btn_n_pin(btn_n), .busy);
	task automatic finish_test;
		$display("compares=%0d bad_count=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] x);
		compares++;
		if (got !== x) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, x);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] x);
		int k = 0;
		@(posedge clk);
		if (!w) exp_q.push_back(x);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= lanes;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 50);
		cyc <= 1'b0;
		stb <= 1'b0;
		if (k >= 50) begin
			chk(0, 1);
			finish_test;
		end
	endtask
	// Read data is judged where ack is sampled, oldest note first
	always @(posedge clk) if (ack === 1'b1 && !we) chk(rdat, exp_q.pop_front());
	task automatic press(input logic [15:0] h);
		int k = 0;
		// Let busy from a previous press settle before it is looked at
		@(posedge clk);
		while (busy === 1'b1 && k < 5000) begin
			@(posedge clk);
			k++;
		end
		if (k >= 5000) chk(0, 1);
		@(posedge clk);
		hold <= h;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
	endtask
	// Counts cycles spent strictly inside a ramp
	task automatic wait_lvl(input logic [9:0] v);
		int k = 0;
		n = 0;
		mn = lvl;
		while (lvl !== v && k < 20000) begin
			@(posedge clk);
			k++;
			if (lvl < mn) mn = lvl;
			if (lvl !== 10'h000 && lvl !== GAMMA_FULL) n++;
		end
		chk({22'h0, lvl}, {22'h0, v});
		if (k >= 20000) finish_test;
	endtask
	initial begin
		r = $urandom(73811);
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		wb(0, ADR_LEVEL, 0, {24'h0, LEVEL_RST});
		wb(0, ADR_FADE_IN, 0, {12'h0, FADE_IN_RST});
		wb(0, 8'h40, 0, 0);
		r = $urandom;
		wb(1, ADR_LEVEL, r, 0);
		lanes = 4'he;
		wb(1, ADR_LEVEL, ~r, 0);
		lanes = 4'hf;
		wb(0, ADR_LEVEL, 0, {24'h0, r[7:0]});
		chk({24'h0, lset}, {24'h0, r[7:0]});
		pwm <= 1'b1;
		wait_lvl(GAMMA_FULL);
		pwm <= 1'b0;
		wait_lvl(10'h000);
		wb(1, ADR_FADE_IN, 0, 0);
		wb(1, ADR_FADE_OUT, 0, 0);
		press(16'h0028);
		wait_lvl(GAMMA_FULL);
		press(16'h0005);
		repeat (60) @(posedge clk);
		chk({22'h0, lvl}, {22'h0, GAMMA_FULL});
		sh <= 1'b1;
		repeat (8) @(posedge clk);
		chk({25'h0, pct}, {25'h0, FULL_PCT});
		repeat (10) @(posedge clk);
		chk({25'h0, pct}, {25'h0, SHORT_PCT});
		sh <= 1'b0;
		repeat (6) @(posedge clk);
		chk({25'h0, pct}, {25'h0, FULL_PCT});
		e = $urandom_range(20, 0);
		trb <= 1'b1;
		exc <= e[7:0];
		repeat (8) @(posedge clk);
		chk({25'h0, pct}, 32'(100 - 3 * e));
		toff <= 1'b1;
		repeat (8) @(posedge clk);
		chk({31'h0, en}, 0);
		toff <= 1'b0;
		press(16'h0028);
		repeat (900) @(posedge clk);
		chk({22'h0, lvl}, 0);
		wb(0, ADR_STATUS, 0, (32'h1 << ST_TBLOCK_BIT) | (32'h1 << ST_BTN_BIT) | (32'(RAMP_OFF) << ST_STATE_LSB));
		trb <= 1'b0;
		exc <= 8'h00;
		press(16'h0028);
		wait_lvl(GAMMA_FULL);
		lock <= 1'b1;
		rec <= 1'b0;
		repeat (8) @(posedge clk);
		chk({31'h0, en}, 0);
		lock <= 1'b0;
		rec <= 1'b1;
		repeat (8) @(posedge clk);
		chk({31'h0, en}, 1);
		chk({22'h0, lvl}, {22'h0, GAMMA_FULL});
		lock <= 1'b1;
		ret <= 1'b1;
		rec <= 1'b0;
		repeat (8) @(posedge clk);
		{lock, ret, rec} <= 3'h1;
		repeat (8) @(posedge clk);
		chk({22'h0, lvl}, 0);
		wb(1, ADR_FADE_IN, 32'h0000_0028, 0);
		wb(1, ADR_FADE_OUT, 32'h0000_0014, 0);
		press(16'h0028);
		wait_lvl(GAMMA_FULL);
		chk({31'h0, n > 900 && n < 1100}, 1);
		press(16'h0028);
		wait_lvl(10'h000);
		chk({31'h0, n > 450 && n < 550}, 1);
		wb(1, ADR_FADE_OUT, 32'h0000_00c8, 0);
		press(16'h0028);
		wait_lvl(GAMMA_FULL);
		press(16'h0028);
		n = 0;
		while (lvl >= 10'h258 && n < 20000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 20000) chk(0, 1);
		pwm <= 1'b1;
		press(16'h0028);
		wait_lvl(GAMMA_FULL);
		chk({31'h0, n > 100}, 1);
		chk({31'h0, mn != 10'h000}, 1);
		finish_test;
	end
endmodule
`default_nettype wire
